//--- dv/czbu_props.sv
`timescale 1ns/1ps
`include "czbu_map.svh"
module czbu_props (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic INSTR_VALID,
  input wire logic [31:0] INSTR,
  input wire logic [63:0] INSTR_PC,
  input wire logic SLOT_VALID,
  input wire logic [4:0] SOURCE_REG_FIELD,
  input wire logic IS_BRANCH,
  input wire logic REDIRECT,
  input wire logic SQUASH_SLOT_INSTR,
  input wire logic LINK_WE,
  input wire logic [4:0] LINK_REG,
  input wire logic [63:0] LINK_DATA
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);
  a_link_reg_fixed: assert property (LINK_REG == `CZBU_LINK_REG) else $error("link reg");
  a_link_strobe: assert property (LINK_WE |-> IS_BRANCH ##1 !LINK_WE) else $error("link strobe");
  a_link_value: assert property (LINK_WE |-> LINK_DATA == $past(INSTR_PC) + `CZBU_LINK_STEP)
    else $error("link data");
  a_link_form: assert property (IS_BRANCH |-> LINK_WE == ($past(INSTR[31:26]) == `CZBU_OPC_REG_IMMEDIATE_GROUP
    && $past(INSTR[20:16]) == `CZBU_SEL_LTZAL)) else $error("link form");
  a_branch_cause: assert property (IS_BRANCH |-> $past(INSTR_VALID)
    && SOURCE_REG_FIELD == $past(INSTR[25:21]) ##1 !IS_BRANCH) else $error("branch pulse");
  a_redirect_once: assert property (REDIRECT |-> $past(SLOT_VALID) && !SQUASH_SLOT_INSTR ##1 !REDIRECT)
    else $error("redirect");
  a_squash_once: assert property (SQUASH_SLOT_INSTR |-> $past(SLOT_VALID) ##1 !SQUASH_SLOT_INSTR)
    else $error("squash");
  a_answer_alone: assert property ((REDIRECT || SQUASH_SLOT_INSTR) |-> !IS_BRANCH) else $error("overlap");
endmodule : czbu_props
bind czbu_unit czbu_props props_u (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .INSTR_VALID(INSTR_VALID), .INSTR(INSTR),
  .INSTR_PC(INSTR_PC), .SLOT_VALID(SLOT_VALID), .SOURCE_REG_FIELD(SOURCE_REG_FIELD), .IS_BRANCH(IS_BRANCH),
  .REDIRECT(REDIRECT), .SQUASH_SLOT_INSTR(SQUASH_SLOT_INSTR), .LINK_WE(LINK_WE), .LINK_REG(LINK_REG),
  .LINK_DATA(LINK_DATA));

//--- dv/czbu_rf_model.sv
`timescale 1ns/1ps
module czbu_rf_model (
  input wire logic clk_sys,
  input wire logic [4:0] src_idx,
  output logic [63:0] src_value,
  input wire logic link_we,
  input wire logic [4:0] link_reg,
  input wire logic [63:0] link_data
);
  logic [63:0] gpr [32];
  // combinational read: the operand must arrive with its instruction
  assign src_value = gpr[src_idx];
  always @(posedge clk_sys) if (link_we) gpr[link_reg] <= link_data;
endmodule : czbu_rf_model

//--- dv/tb_top.sv
`timescale 1ns/1ps
`include "czbu_map.svh"
module tb_top;
  logic clk = 1'b0, rst_n = 1'b0, ivalid = 1'b0, svalid = 1'b0;
  logic [31:0] instr = '0;
  logic [63:0] pc = 64'h0000_0000_1000_0000;
  logic [63:0] src, tgt, ldata;
  logic [4:0] lreg;
  logic is_br, redir, squash, lwe;
  logic [63:0] vals [4] = '{'0, 64'h0000_0000_0000_0001, {1'b1, 63'h0}, {1'b0, {63{1'b1}}}};
  int fails = 0, samples_checked = 0;
  always #25 clk = ~clk;
  czbu_unit dut_u (.CLK_SYS(clk), .RESET_N(rst_n), .INSTR_VALID(ivalid), .INSTR(instr), .INSTR_PC(pc),
    .SOURCE_REG_VALUE(src), .SLOT_VALID(svalid), .SOURCE_REG_FIELD(), .IS_BRANCH(is_br), .REDIRECT(redir),
    .REDIRECT_PC(tgt), .SQUASH_SLOT_INSTR(squash), .LINK_WE(lwe), .LINK_REG(lreg), .LINK_DATA(ldata));
  czbu_rf_model partner_u (.clk_sys(clk), .src_idx(instr[25:21]), .src_value(src), .link_we(lwe),
    .link_reg(lreg), .link_data(ldata));
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask : cmp
  task automatic run_br(input logic [5:0] op, input logic [4:0] sel, input logic [15:0] disp, input logic [63:0] v,
    input logic take, input logic lik);
    partner_u.gpr[5] = v;
    @(negedge clk);
    instr = {op, 5'h05, sel, disp};
    ivalid = 1'b1;
    @(negedge clk);
    {ivalid, svalid} = 2'b01;
    cmp(is_br, 1'b1, "decode");
    @(negedge clk);
    svalid = 1'b0;
    cmp(redir, take, "redirect");
    cmp(squash, lik & ~take, "squash");
    if (take) cmp(tgt, pc + `CZBU_SLOT_STEP + {{46{disp[15]}}, disp, 2'h0}, "target");
    @(negedge clk);
    cmp(redir | squash, 1'b0, "pulse");
  endtask : run_br
  task automatic t_cond();
    logic [63:0] v;
    for (int i = 0; i < 8; i++) begin
      v = vals[i % 4];
      run_br(i < 4 ? `CZBU_OPC_GTZ : `CZBU_OPC_GTZL, 5'h00, 16'h7fff, v, !v[63] && |v, i > 3);
      run_br(i < 4 ? `CZBU_OPC_LEZ : `CZBU_OPC_LEZL, 5'h00, 16'h8000, v, v[63] || ~|v, i > 3);
      run_br(`CZBU_OPC_REG_IMMEDIATE_GROUP, `CZBU_SEL_LTZ, 16'hfff0, v, v[63], 1'b0);
      // likely forms run both taken and not-taken here; the taken-rate advice binds code generators
      run_br(`CZBU_OPC_REG_IMMEDIATE_GROUP, `CZBU_SEL_GEZL, 16'h0010, v, !v[63], 1'b1);
    end
    $display("test conditions done");
  endtask : t_cond
  task automatic t_link();
    for (int i = 1; i < 3; i++) begin
      run_br(`CZBU_OPC_REG_IMMEDIATE_GROUP, `CZBU_SEL_LTZAL, 16'h8000, vals[i], vals[i][63], 1'b0);
      cmp(partner_u.gpr[31], pc + `CZBU_LINK_STEP, "link");
      pc = pc + 64'h0000_0000_0001_0000;
    end
    $display("test link done");
  endtask : t_link
  task automatic t_reject();
    logic [31:0] words [3];
    words = '{{`CZBU_OPC_GTZ, 5'h05, 5'h01, 16'h0004}, {`CZBU_OPC_REG_IMMEDIATE_GROUP, 5'h05, 5'h01, 16'h0004},
      {`CZBU_OPC_LEZ, 5'h05, 5'h00, 16'h0004}};
    for (int i = 0; i < 3; i++) begin
      @(negedge clk);
      instr = words[i];
      ivalid = (i < 2);
      svalid = 1'b1;
      @(negedge clk);
      {ivalid, svalid} = 2'h0;
      cmp(is_br | lwe, 1'b0, "not a branch");
      @(negedge clk);
      cmp(redir | squash, 1'b0, "no answer");
    end
    $display("test reject done");
  endtask : t_reject
  task automatic t_reset();
    partner_u.gpr[5] = vals[3];
    @(negedge clk);
    instr = {`CZBU_OPC_GTZ, 5'h05, 5'h00, 16'h0040};
    ivalid = 1'b1;
    @(negedge clk);
    ivalid = 1'b0;
    rst_n = 1'b0;
    @(negedge clk);
    cmp(is_br | redir | squash | lwe, 1'b0, "outputs in reset");
    cmp(lreg, `CZBU_LINK_REG, "link reg in reset");
    rst_n = 1'b1;
    svalid = 1'b1;
    @(negedge clk);
    svalid = 1'b0;
    cmp(is_br | redir | squash, 1'b0, "first edge after reset");
    @(negedge clk);
    cmp(is_br | redir | squash, 1'b0, "second edge after reset");
    run_br(`CZBU_OPC_GTZ, 5'h00, 16'h0040, vals[3], 1'b1, 1'b0);
    $display("test reset done");
  endtask : t_reset
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  initial begin
    partner_u.gpr[0] = '0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    t_cond();
    t_link();
    t_reject();
    t_reset();
    summarize();
  end
endmodule : tb_top

//--- logic/czbu_dec_if.sv
`timescale 1ns/1ps
interface czbu_dec_if;
  import czbu_pkg::*;
  logic [31:0] instr;
  logic valid;
  czbu_pkg::czbu_cond_t cond;
  logic likely;
  logic link;
  logic [4:0] src;
  logic [15:0] disp;
  modport dec (input instr, input valid, output cond, output likely, output link, output src, output disp);
  modport use_side (output instr, output valid, input cond, input likely, input link, input src, input disp);
endinterface : czbu_dec_if

//--- logic/czbu_decode.sv
`timescale 1ns/1ps
`include "czbu_map.svh"
module czbu_decode
  import czbu_pkg::*;
(
  czbu_dec_if.dec d
);
  logic [5:0] opc;
  logic [4:0] sel;
  always_comb begin
    opc = d.instr[`CZBU_OPC_HI:`CZBU_OPC_LO];
    sel = d.instr[`CZBU_SEL_HI:`CZBU_SEL_LO];
    d.cond = CZBU_OP_NONE;
    d.likely = 1'b0;
    d.link = 1'b0;
    d.src = d.instr[`CZBU_SRC_HI:`CZBU_SRC_LO];
    d.disp = d.instr[`CZBU_DISP_HI:`CZBU_DISP_LO];
    if (d.valid) begin
      if (opc == `CZBU_OPC_GTZ && sel == `CZBU_SEL_ZERO) begin
        d.cond = CZBU_OP_GTZ;
      end else if (opc == `CZBU_OPC_GTZL && sel == `CZBU_SEL_ZERO) begin
        d.cond = CZBU_OP_GTZ;
        d.likely = 1'b1;
      end else if (opc == `CZBU_OPC_LEZ && sel == `CZBU_SEL_ZERO) begin
        d.cond = CZBU_OP_LEZ;
      end else if (opc == `CZBU_OPC_LEZL && sel == `CZBU_SEL_ZERO) begin
        d.cond = CZBU_OP_LEZ;
        d.likely = 1'b1;
      end else if (opc == `CZBU_OPC_REG_IMMEDIATE_GROUP && sel == `CZBU_SEL_LTZ) begin
        d.cond = CZBU_OP_LTZ;
      end else if (opc == `CZBU_OPC_REG_IMMEDIATE_GROUP && sel == `CZBU_SEL_LTZAL) begin
        d.cond = CZBU_OP_LTZ;
        d.link = 1'b1;
      end else if (opc == `CZBU_OPC_REG_IMMEDIATE_GROUP && sel == `CZBU_SEL_GEZL) begin
        d.cond = CZBU_OP_GEZ;
        d.likely = 1'b1;
      end
    end
  end
endmodule : czbu_decode

//--- logic/czbu_map.svh
`ifndef CZBU_MAP_SVH
`define CZBU_MAP_SVH
`define CZBU_OPC_HI 31
`define CZBU_OPC_LO 26
`define CZBU_SRC_HI 25
`define CZBU_SRC_LO 21
`define CZBU_SEL_HI 20
`define CZBU_SEL_LO 16
`define CZBU_DISP_HI 15
`define CZBU_DISP_LO 0
`define CZBU_OPC_GTZ 6'h07
`define CZBU_OPC_GTZL 6'h17
`define CZBU_OPC_LEZ 6'h06
`define CZBU_OPC_LEZL 6'h16
`define CZBU_OPC_REG_IMMEDIATE_GROUP 6'h01
`define CZBU_SEL_ZERO 5'h00
`define CZBU_SEL_LTZ 5'h00
`define CZBU_SEL_GEZL 5'h03
`define CZBU_SEL_LTZAL 5'h10
`define CZBU_LINK_REG 5'h1f
`define CZBU_SLOT_STEP 4
`define CZBU_LINK_STEP 8
`define CZBU_SHIFT 2
`endif

//--- logic/czbu_pkg.sv
package czbu_pkg;
  typedef enum logic [2:0] {
    CZBU_OP_NONE = 3'b000,
    CZBU_OP_GTZ = 3'b001,
    CZBU_OP_LEZ = 3'b010,
    CZBU_OP_LTZ = 3'b011,
    CZBU_OP_GEZ = 3'b100
  } czbu_cond_t;
  typedef enum logic [1:0] {
    CZBU_ST_IDLE = 2'b00,
    CZBU_ST_SLOT = 2'b01
  } czbu_state_t;
endpackage : czbu_pkg

//--- logic/czbu_unit.sv
`timescale 1ns/1ps
`include "czbu_map.svh"
module czbu_unit
  import czbu_pkg::*;
#(
  parameter int GP_REGISTER_WIDTH = 64,
  parameter int ADDR_WIDTH = 64
)(
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic INSTR_VALID,
  input wire logic [31:0] INSTR,
  input wire logic [ADDR_WIDTH-1:0] INSTR_PC,
  input wire logic [GP_REGISTER_WIDTH-1:0] SOURCE_REG_VALUE,
  input wire logic SLOT_VALID,
  output logic [4:0] SOURCE_REG_FIELD,
  output logic IS_BRANCH,
  output logic REDIRECT,
  output logic [ADDR_WIDTH-1:0] REDIRECT_PC,
  output logic SQUASH_SLOT_INSTR,
  output logic LINK_WE,
  output logic [4:0] LINK_REG,
  output logic [GP_REGISTER_WIDTH-1:0] LINK_DATA
);
  czbu_dec_if dif ();
  czbu_decode u_decode (.d(dif.dec));
  assign dif.instr = INSTR;
  assign dif.valid = INSTR_VALID;

  // sign-extended byte displacement; 18 bits gives the 128 KByte reach
  function automatic logic [ADDR_WIDTH-1:0] disp_ext(input logic [15:0] disp);
    logic [17:0] sh;
    sh = {2'h0, disp} << `CZBU_SHIFT;
    disp_ext = {{(ADDR_WIDTH-18){sh[17]}}, sh};
  endfunction : disp_ext

  function automatic logic cond_met(input czbu_cond_t c, input logic [GP_REGISTER_WIDTH-1:0] v);
    logic neg;
    logic zero;
    neg = v[GP_REGISTER_WIDTH-1];
    zero = (v == '0);
    case (c)
      CZBU_OP_GTZ: cond_met = !neg && !zero;
      CZBU_OP_LEZ: cond_met = neg || zero;
      CZBU_OP_LTZ: cond_met = neg;
      CZBU_OP_GEZ: cond_met = !neg;
      default: cond_met = 1'b0;
    endcase
  endfunction : cond_met

  // the slot and link addresses both step the branch address
  function automatic logic [ADDR_WIDTH-1:0] pc_plus(input logic [ADDR_WIDTH-1:0] pc, input int step);
    pc_plus = pc + ADDR_WIDTH'(step);
  endfunction : pc_plus

  // terms shared by the groups below
  logic accept;
  logic cond_true;
  logic slot_seen;
  logic [ADDR_WIDTH-1:0] slot_pc;
  logic [ADDR_WIDTH-1:0] link_pc;
  logic [ADDR_WIDTH-1:0] branch_target;

  // branch hold group: what the slot edge acts on
  czbu_state_t state;
  czbu_state_t next_state;
  logic taken;
  logic next_taken;
  logic likely;
  logic next_likely;
  logic [ADDR_WIDTH-1:0] target;
  logic [ADDR_WIDTH-1:0] next_target;

  // decode pulse group
  logic is_branch;
  logic next_is_branch;
  logic [4:0] src_q;
  logic [4:0] next_src_q;

  // slot answer group
  logic redirect;
  logic next_redirect;
  logic [ADDR_WIDTH-1:0] redirect_pc;
  logic [ADDR_WIDTH-1:0] next_redirect_pc;
  logic squash;
  logic next_squash;

  // link group
  logic link_we;
  logic next_link_we;
  logic [GP_REGISTER_WIDTH-1:0] link_data;
  logic [GP_REGISTER_WIDTH-1:0] next_link_data;
  logic [4:0] link_reg;
  logic [4:0] next_link_reg;

  // no exception path at all: faults belong to the slot or the target fetch
  always_comb begin
    slot_pc = pc_plus(INSTR_PC, `CZBU_SLOT_STEP);
    link_pc = pc_plus(INSTR_PC, `CZBU_LINK_STEP);
    branch_target = slot_pc + disp_ext(dif.disp);
    // words arriving while a slot is owed are the slot itself, never a branch
    accept = (state == CZBU_ST_IDLE) && (dif.cond != CZBU_OP_NONE);
    // evaluated in the branch's own cycle, full-width signed
    cond_true = cond_met(dif.cond, SOURCE_REG_VALUE);
    slot_seen = (state == CZBU_ST_SLOT) && SLOT_VALID;
  end

  always_comb begin
    next_state = state;
    next_taken = taken;
    next_likely = likely;
    next_target = target;
    case (state)
      CZBU_ST_IDLE: begin
        if (accept) begin
          next_state = CZBU_ST_SLOT;
          next_taken = cond_true;
          next_likely = dif.likely;
          next_target = branch_target;
        end
      end
      CZBU_ST_SLOT: begin
        // the delay slot goes first; the answer follows its edge
        if (SLOT_VALID) begin
          next_state = CZBU_ST_IDLE;
        end
      end
      default: begin
        next_state = CZBU_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      state <= CZBU_ST_IDLE;
      taken <= 1'b0;
      likely <= 1'b0;
      target <= '0;
    end else begin
      state <= next_state;
      taken <= next_taken;
      likely <= next_likely;
      target <= next_target;
    end
  end

  // field copy follows every word so fetch can match it without a qualifier
  always_comb begin
    next_is_branch = accept;
    next_src_q = dif.src;
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      is_branch <= 1'b0;
      src_q <= '0;
    end else begin
      is_branch <= next_is_branch;
      src_q <= next_src_q;
    end
  end

  always_comb begin
    next_redirect = 1'b0;
    next_redirect_pc = redirect_pc;
    next_squash = 1'b0;
    if (slot_seen) begin
      if (taken) begin
        next_redirect = 1'b1;
        next_redirect_pc = target;
      end else if (likely) begin
        // no static prediction here, so a not-taken likely costs nothing extra
        next_squash = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      redirect <= 1'b0;
      redirect_pc <= '0;
      squash <= 1'b0;
    end else begin
      redirect <= next_redirect;
      redirect_pc <= next_redirect_pc;
      squash <= next_squash;
    end
  end

  always_comb begin
    next_link_we = 1'b0;
    next_link_data = link_data;
    next_link_reg = `CZBU_LINK_REG;
    if (accept && dif.link) begin
      // link written whether or not the branch is taken
      next_link_we = 1'b1;
      next_link_data = GP_REGISTER_WIDTH'(link_pc);
    end
  end

  // link register index is a flop too, so every output leaves a register
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      link_we <= 1'b0;
      link_data <= '0;
      link_reg <= `CZBU_LINK_REG;
    end else begin
      link_we <= next_link_we;
      link_data <= next_link_data;
      link_reg <= next_link_reg;
    end
  end

  assign SOURCE_REG_FIELD = src_q;
  assign IS_BRANCH = is_branch;
  assign REDIRECT = redirect;
  assign REDIRECT_PC = redirect_pc;
  assign SQUASH_SLOT_INSTR = squash;
  assign LINK_WE = link_we;
  assign LINK_REG = link_reg;
  assign LINK_DATA = link_data;
endmodule : czbu_unit
